// ==== pkg/relay_map.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef RELAY_MAP_SVH
`define RELAY_MAP_SVH

// =====================================================================
// register offsets (byte addresses)
`define RLY_FOUR_SRC_OFS   8'h00
`define RLY_FOUR_ON_OFS    8'h04
`define RLY_FOUR_OFF_OFS   8'h08
`define RLY_FIVE_SRC_OFS   8'h0C
`define RLY_OVERRIDE_OFS   8'h10
`define RLY_STATUS_OFS     8'h14

// =====================================================================
// source register fields
`define RLY_SRC_CODE_LSB   0
`define RLY_SRC_CODE_MSB   7
`define RLY_SRC_PTR_EN_BIT 8
`define RLY_SRC_PTR_LSB    16
`define RLY_SRC_PTR_MSB    23

// =====================================================================
// override word bits
`define RLY_OVR_FOUR_BIT   3
`define RLY_OVR_FIVE_BIT   4

// =====================================================================
// status word fields
`define RLY_HOA_ILK2_BIT   9
`define RLY_HOA_ILK3_BIT   10
`define RLY_HOA_ILK4_BIT   11
`define RLY_HOA_ALL_BIT    12
`define RLY_LOAD_OUT_BIT   3

// =====================================================================
// reset values
`define RLY_SRC_RST        32'h0000_0000
`define RLY_DLY_RST        12'h000
`define RLY_OVR_RST        16'h0000

// =====================================================================
// timing: delays count whole seconds, 0 to 3000 s
`define RLY_DLY_MAX_S      12'h0BB8
`define RLY_SEC_NS         32'h3B9A_CA00
`define RLY_CLK_NS         32'h0000_000A
`define RLY_TICKS_PER_SEC  (`RLY_SEC_NS / `RLY_CLK_NS)

`endif

// ==== pkg/relay_pkg.sv ====
// types shared by the relay source and delay logic
// assumes relay_map.svh holds the numbers
package relay_pkg;

    // source selection codes
    typedef enum logic [7:0] {
        SRC_OFF      = 8'h00,
        SRC_ON       = 8'h01,
        SRC_ILK2     = 8'h39,
        SRC_ILK3     = 8'h3A,
        SRC_ILK4     = 8'h3B,
        SRC_ILK_ALL  = 8'h3C,
        SRC_LOAD     = 8'h3D,
        SRC_OVERRIDE = 8'h3E
    } src_code_e;

    // delay timer states
    typedef enum logic [1:0] {
        TMR_STABLE = 2'b01,
        TMR_WAIT   = 2'b10
    } tmr_state_e;

    typedef logic [11:0] dly_sec_t;

endpackage

// ==== core/relay_delay_timer.sv ====
// on/off delay for one relay output
// assumes src_level synchronous to sys_clk; delays in whole seconds
`timescale 1ns/1ps
`include "relay_map.svh"

module relay_delay_timer #(
    parameter int TICKS_PER_SEC = `RLY_TICKS_PER_SEC
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // source and delays
    input  wire logic              src_level,
    input  wire relay_pkg::dly_sec_t on_delay,
    input  wire relay_pkg::dly_sec_t off_delay,
    // relay drive
    output logic                   relay_state
);
    import relay_pkg::*;

    localparam int SUB_W = $clog2(TICKS_PER_SEC + 1);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICKS_PER_SEC - 1);

    tmr_state_e       state_ff;
    logic             relay_ff;
    logic [SUB_W-1:0] sub_ff;
    dly_sec_t         sec_ff;
    dly_sec_t         target;
    logic             mismatch;
    logic             sec_done;

    assign target      = relay_ff ? off_delay : on_delay;
    assign mismatch    = src_level != relay_ff;
    assign sec_done    = (sub_ff == SUB_LAST) && ((sec_ff + 12'h001) >= target);
    assign relay_state = relay_ff;

    // =================================================================
    // state and relay
    // flip only after hold
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= TMR_STABLE;
            relay_ff <= 1'b0;
        end else if (!mismatch) begin
            state_ff <= TMR_STABLE;
        end else begin
            unique case (state_ff)
                TMR_STABLE: begin
                    if (target == `RLY_DLY_RST)
                        relay_ff <= src_level;
                    else
                        state_ff <= TMR_WAIT;
                end
                TMR_WAIT: begin
                    if (sec_done) begin
                        relay_ff <= src_level;
                        state_ff <= TMR_STABLE;
                    end
                end
                default: state_ff <= TMR_STABLE;
            endcase
        end
    end

    // =================================================================
    // second prescaler and second count, restarted per mismatch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_ff <= '0;
            sec_ff <= `RLY_DLY_RST;
        end else if (state_ff != TMR_WAIT || !mismatch) begin
            sub_ff <= '0;
            sec_ff <= `RLY_DLY_RST;
        end else if (sub_ff == SUB_LAST) begin
            sub_ff <= '0;
            sec_ff <= sec_ff + 12'h001;
        end else begin
            sub_ff <= sub_ff + SUB_W'(1);
        end
    end

    // =================================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence stable_mismatch_s;
        state_ff == TMR_STABLE && mismatch;
    endsequence

    zero_delay_follow_a: assert property (
        (stable_mismatch_s and (target == `RLY_DLY_RST)) |=> relay_ff == $past(src_level))
        else $error("zero delay did not follow source");
    rise_after_hold_a: assert property (
        $rose(relay_ff) |-> $past(src_level) && ($past(on_delay) == `RLY_DLY_RST || $past(sec_done)))
        else $error("relay energized before on delay ran out");
    fall_after_hold_a: assert property (
        $fell(relay_ff) |-> !$past(src_level) && ($past(off_delay) == `RLY_DLY_RST || $past(sec_done)))
        else $error("relay released before off delay ran out");
    wait_entry_a: assert property (
        (stable_mismatch_s and (target != `RLY_DLY_RST)) |=> state_ff == TMR_WAIT && relay_ff == $past(relay_ff))
        else $error("nonzero delay did not start waiting");

endmodule

// ==== core/relay_output_source_delay.sv ====
// relay output source selection for outputs four and five, with delays for output four
// assumes classic Wishbone master on sys_clk; status words synchronous
//
// How it works
// - codes 57 to 60 route interlock bits 9 to 12 of the HOA word
// - code 61 routes bit 3 of the load curve monitor status word
// - code 62 routes the output override word bit, four uses bit 3, five bit 4
// - pointer mode selects any single drive status bit as source
// - output four energizes after a 0 to 3000 s on delay
// - output four releases after a 0 to 3000 s off delay
// - output five has its own selector, resetting to de-energized
// - code 0 holds relay off, code 1 holds relay on
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "relay_map.svh"

module relay_output_source_delay #(
    parameter int STATUS_BITS   = 256,
    parameter int PTR_W         = 8,
    parameter int TICKS_PER_SEC = `RLY_TICKS_PER_SEC
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // drive status
    input  wire logic [15:0]            hoa_status_word,
    input  wire logic [15:0]            load_curve_monitor,
    input  wire logic [STATUS_BITS-1:0] drive_status_bits,
    // relay drives
    output logic                        relay_out_four,
    output logic                        relay_out_five
);
    import relay_pkg::*;

    // =================================================================
    // registers
    logic [31:0]  four_src_ff;
    logic [31:0]  five_src_ff;
    dly_sec_t     four_on_ff;
    dly_sec_t     four_off_ff;
    logic [15:0]  output_override_word;
    logic         relay_five_ff;
    logic         ack_ff;
    logic [31:0]  rdat_ff;
    logic         wb_req;
    logic         wb_wr;
    logic [31:0]  rd_mux;
    logic         four_lvl;
    logic         five_lvl;
    logic         relay_four_st;
    logic         five_written_ff;

    // =================================================================
    // helpers
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic dly_sec_t clamp_dly(input logic [31:0] v);
        dly_sec_t res;
        res = (v > 32'(`RLY_DLY_MAX_S)) ? `RLY_DLY_MAX_S : v[11:0];
        return res;
    endfunction

    // level picked by a source register
    function automatic logic src_level(
        input logic [31:0]            src,
        input logic                   ovr_bit,
        input logic [15:0]            hoa,
        input logic [15:0]            load,
        input logic [STATUS_BITS-1:0] drv
    );
        logic              res;
        logic [PTR_W-1:0]  ptr;
        ptr = src[`RLY_SRC_PTR_LSB +: PTR_W];
        res = 1'b0;
        if (src[`RLY_SRC_PTR_EN_BIT]) begin
            res = drv[ptr];
        end else begin
            case (src[`RLY_SRC_CODE_MSB:`RLY_SRC_CODE_LSB])
                SRC_OFF:      res = 1'b0;
                SRC_ON:       res = 1'b1;
                SRC_ILK2:     res = hoa[`RLY_HOA_ILK2_BIT];
                SRC_ILK3:     res = hoa[`RLY_HOA_ILK3_BIT];
                SRC_ILK4:     res = hoa[`RLY_HOA_ILK4_BIT];
                SRC_ILK_ALL:  res = hoa[`RLY_HOA_ALL_BIT];
                SRC_LOAD:     res = load[`RLY_LOAD_OUT_BIT];
                SRC_OVERRIDE: res = ovr_bit;
                default:      res = 1'b0;
            endcase
        end
        return res;
    endfunction

    // =================================================================
    // wishbone access
    assign wb_req   = wb_cyc_i && wb_stb_i && !ack_ff;
    // write lands at the edge the master sees ack
    assign wb_wr    = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            ack_ff <= 1'b0;
        else
            ack_ff <= wb_req;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            `RLY_FOUR_SRC_OFS: rd_mux = four_src_ff;
            `RLY_FOUR_ON_OFS:  rd_mux = {20'h0_0000, four_on_ff};
            `RLY_FOUR_OFF_OFS: rd_mux = {20'h0_0000, four_off_ff};
            `RLY_FIVE_SRC_OFS: rd_mux = five_src_ff;
            `RLY_OVERRIDE_OFS: rd_mux = {16'h0000, output_override_word};
            `RLY_STATUS_OFS:   rd_mux = {28'h000_0000, five_lvl, four_lvl, relay_five_ff, relay_four_st};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rdat_ff <= 32'h0000_0000;
        else if (wb_req && !wb_we_i)
            rdat_ff <= rd_mux;
    end

    // =================================================================
    // source registers; unused fields read zero
    localparam logic [31:0] SRC_MASK = 32'h00FF_01FF;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            four_src_ff <= `RLY_SRC_RST;
        end else if (wb_wr && wb_adr_i == `RLY_FOUR_SRC_OFS) begin
            four_src_ff <= be_merge(four_src_ff, wb_dat_i, wb_sel_i) & SRC_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            five_src_ff     <= `RLY_SRC_RST;
            five_written_ff <= 1'b0;
        end else if (wb_wr && wb_adr_i == `RLY_FIVE_SRC_OFS) begin
            five_src_ff     <= be_merge(five_src_ff, wb_dat_i, wb_sel_i) & SRC_MASK;
            five_written_ff <= 1'b1;
        end
    end

    // =================================================================
    // delay registers, clamped to the legal range
    // on delay setting
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            four_on_ff <= `RLY_DLY_RST;
        else if (wb_wr && wb_adr_i == `RLY_FOUR_ON_OFS)
            four_on_ff <= clamp_dly(be_merge({20'h0_0000, four_on_ff}, wb_dat_i, wb_sel_i));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            four_off_ff <= `RLY_DLY_RST;
        else if (wb_wr && wb_adr_i == `RLY_FOUR_OFF_OFS)
            four_off_ff <= clamp_dly(be_merge({20'h0_0000, four_off_ff}, wb_dat_i, wb_sel_i));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            output_override_word <= `RLY_OVR_RST;
        else if (wb_wr && wb_adr_i == `RLY_OVERRIDE_OFS)
            output_override_word <= 16'(be_merge({16'h0000, output_override_word}, wb_dat_i, wb_sel_i));
    end

    // =================================================================
    // source levels
    assign four_lvl = src_level(four_src_ff, output_override_word[`RLY_OVR_FOUR_BIT],
                                hoa_status_word, load_curve_monitor, drive_status_bits);
    assign five_lvl = src_level(five_src_ff, output_override_word[`RLY_OVR_FIVE_BIT],
                                hoa_status_word, load_curve_monitor, drive_status_bits);

    // =================================================================
    // relay four with delays
    // delayed relay four
    relay_delay_timer #(
        .TICKS_PER_SEC (TICKS_PER_SEC)
    ) u_four_timer (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .src_level   (four_lvl),
        .on_delay    (four_on_ff),
        .off_delay   (four_off_ff),
        .relay_state (relay_four_st)
    );
    assign relay_out_four = relay_four_st;

    // relay five follows its source one cycle later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            relay_five_ff <= 1'b0;
        else
            relay_five_ff <= five_lvl;
    end
    assign relay_out_five = relay_five_ff;

    // =================================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] four_code;
    logic       four_ptr;
    assign four_code = four_src_ff[`RLY_SRC_CODE_MSB:`RLY_SRC_CODE_LSB];
    assign four_ptr  = four_src_ff[`RLY_SRC_PTR_EN_BIT];

    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence wb_ack_once_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    ack_pulse_a: assert property (
        wb_req_s |=> wb_ack_once_s)
        else $error("wishbone ack not a single pulse after request");
    code_off_level_a: assert property (
        !four_ptr && four_code == SRC_OFF |-> !four_lvl)
        else $error("code 0 did not hold relay four off");
    code_on_level_a: assert property (
        !four_ptr && four_code == SRC_ON |-> four_lvl)
        else $error("code 1 did not hold relay four on");
    interlock_route_a: assert property (
        !four_ptr && four_code >= 8'h39 && four_code <= 8'h3C
        |-> four_lvl == hoa_status_word[4'(four_code - 8'h30)])
        else $error("interlock code routed wrong bit");
    load_curve_route_a: assert property (
        !four_ptr && four_code == SRC_LOAD |-> four_lvl == load_curve_monitor[3])
        else $error("load curve code routed wrong bit");
    override_four_a: assert property (
        !four_ptr && four_code == SRC_OVERRIDE |-> four_lvl == output_override_word[3])
        else $error("override code routed wrong bit for four");
    override_five_a: assert property (
        !five_src_ff[8] && five_src_ff[7:0] == SRC_OVERRIDE
        |=> relay_out_five == $past(output_override_word[4]))
        else $error("override code routed wrong bit for five");
    pointer_route_a: assert property (
        four_ptr |-> four_lvl == drive_status_bits[four_src_ff[16 +: PTR_W]])
        else $error("pointer source routed wrong bit");
    five_default_a: assert property (
        !five_written_ff |-> five_src_ff == 32'h0000_0000 && !relay_out_five)
        else $error("relay five not de-energized by default");
    delay_clamp_a: assert property (
        four_on_ff <= `RLY_DLY_MAX_S && four_off_ff <= `RLY_DLY_MAX_S)
        else $error("delay beyond 3000 s");
    hold_unchanged_a: assert property (
        relay_out_four == four_lvl && $stable(four_lvl) |=> $stable(relay_out_four))
        else $error("relay four changed while source stayed equal");

endmodule

// ==== sim/relay_contact.sv ====
// relay contact model for the far side of one relay drive
// assumes coil drive synchronous to sys_clk, energized high
`timescale 1ns/1ps

module relay_contact #(
    parameter int SETTLE = 2
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // coil and contact
    input  wire logic coil,
    output logic       closed,
    output logic [7:0] flips
);
    logic [3:0] settle_ff;
    logic       closed_ff;
    logic [7:0] flips_ff;

    assign closed = closed_ff;
    assign flips  = flips_ff;

    // =====================================================================
    // contact follows coil once it has stayed put for the settle time
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_ff <= 4'h0;
            closed_ff <= 1'b0;
            flips_ff  <= 8'h00;
        end else if (coil === closed_ff) begin
            settle_ff <= 4'h0;
        end else if (settle_ff >= SETTLE[3:0]) begin
            settle_ff <= 4'h0;
            closed_ff <= ~closed_ff;
            flips_ff  <= flips_ff + 8'h01;
        end else begin
            settle_ff <= settle_ff + 4'h1;
        end
    end
endmodule

// ==== sim/testbench.sv ====
// register-level regression of relay source selection and delays
// assumes the relay map header and relay_pkg are compiled first
`timescale 1ns/1ps
`include "relay_map.svh"

module testbench;
    import relay_pkg::*;

    localparam int TICKS = 4;

    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         wb_cyc_i = 1'b0;
    logic         wb_stb_i = 1'b0;
    logic         wb_we_i = 1'b0;
    logic [7:0]   wb_adr_i = 8'h00;
    logic [3:0]   wb_sel_i = 4'h0;
    logic [31:0]  wb_dat_i = 32'h0000_0000;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic [15:0]  hoa = 16'h0000;
    logic [15:0]  load = 16'h0000;
    logic [255:0] drv = '0;
    logic         relay_four;
    logic         relay_five;
    logic         contact_four;
    logic         contact_five;
    int           miscompares = 0;
    int           checked = 0;

    always #5 sys_clk = ~sys_clk;

    relay_output_source_delay #(.STATUS_BITS(256), .PTR_W(8), .TICKS_PER_SEC(TICKS)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hoa_status_word(hoa),
        .load_curve_monitor(load), .drive_status_bits(drv),
        .relay_out_four(relay_four), .relay_out_five(relay_five));

    relay_contact contact_four_u (.sys_clk(sys_clk), .rst_n(rst_n), .coil(relay_four),
        .closed(contact_four), .flips());
    relay_contact contact_five_u (.sys_clk(sys_clk), .rst_n(rst_n), .coil(relay_five),
        .closed(contact_five), .flips());

    // =====================================================================
    // bus and compare tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                             output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            $display("[ERR] ack expected 1 seen %b", wb_ack_o);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wb_access(1'b1, adr, dat, rd);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_access(1'b0, adr, 32'h0000_0000, rd);
        check(what, rd, exp);
    endtask

    // drive one status bit (inv: all others high instead) in the word picked by kind, every word for kind 3
    task automatic stim(input int kind, input int b, input logic inv);
        logic [255:0] m;
        m = 256'h1 << b;
        if (inv) m = ~m;
        @(posedge sys_clk);
        hoa  <= (kind == 0 || kind == 3) ? m[15:0] : 16'h0000;
        load <= (kind == 1 || kind == 3) ? m[15:0] : 16'h0000;
        drv  <= (kind == 4 || kind == 3) ? m : '0;
        wr(`RLY_OVERRIDE_OFS, {16'h0000, (kind == 2 || kind == 3) ? m[15:0] : 16'h0000});
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic edges_until(input logic lvl, output int n);
        n = 0;
        @(negedge sys_clk);
        while (relay_four !== lvl && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // =====================================================================
    // tests
    initial begin
        #500_000;
        miscompares++;
        $display("[ERR] watchdog expected done seen hang");
        give_verdict();
    end

    initial begin
        logic [7:0] codes [9] = '{8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h01, 8'h00, 8'h00};
        int         kinds [9] = '{0, 0, 0, 0, 1, 2, 3, 3, 4};
        int         bits  [9] = '{9, 10, 11, 12, 3, 3, 256, 256, 200};
        int         n;
        int         hi;
        logic [7:0] ofs;
        logic       seen;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check("relay_four reset", {31'h0, relay_four}, 32'h0000_0000);
        check("relay_five reset", {31'h0, relay_five}, 32'h0000_0000);
        for (int a = 0; a <= 8'h14; a += 4) begin
            rd_chk("register reset", a[7:0], 32'h0000_0000);
        end
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        $display("test reset done");

        for (int o = 0; o < 2; o++) begin
            ofs = (o == 0) ? `RLY_FOUR_SRC_OFS : `RLY_FIVE_SRC_OFS;
            for (int i = 0; i < 9; i++) begin
                wr(ofs, {8'h00, 8'd200, 7'h00, i == 8, codes[i]});
                stim(kinds[i], bits[i] + ((kinds[i] == 2) ? o : 0), 1'b1);
                seen = (o == 0) ? relay_four : relay_five;
                check("relay others high", {31'h0, seen}, {31'h0, i == 6});
                stim(kinds[i], bits[i] + ((kinds[i] == 2) ? o : 0), 1'b0);
                seen = (o == 0) ? relay_four : relay_five;
                check("relay target only", {31'h0, seen}, {31'h0, i != 7});
            end
            wr(ofs, 32'h0000_0000);
        end
        $display("test source selection done");

        stim(0, 256, 1'b0);
        wr(`RLY_FOUR_SRC_OFS, 32'h0000_0039);
        wr(`RLY_FOUR_ON_OFS, 32'h0000_0002);
        wr(`RLY_FOUR_OFF_OFS, 32'h0000_0001);
        @(posedge sys_clk);
        hoa <= 16'h0200;
        repeat (6) @(posedge sys_clk);
        hoa <= 16'h0000;
        hi = 0;
        repeat (30) begin
            @(negedge sys_clk);
            hi += (relay_four !== 1'b0);
        end
        check("short pulse", hi, 0);
        @(posedge sys_clk);
        hoa <= 16'h0200;
        edges_until(1'b1, n);
        check("on delay edges", n, 1 + 2 * TICKS);
        repeat (6) @(posedge sys_clk);
        check("contact closed", {31'h0, contact_four}, 32'h0000_0001);
        rd_chk("status on", `RLY_STATUS_OFS, 32'h0000_0005);
        @(posedge sys_clk);
        hoa <= 16'h0000;
        edges_until(1'b0, n);
        check("off delay edges", n, 1 + TICKS);
        repeat (6) @(posedge sys_clk);
        check("contact open", {31'h0, contact_four}, 32'h0000_0000);
        wr(`RLY_FOUR_ON_OFS, 32'h0000_FFFF);
        rd_chk("on delay clamp", `RLY_FOUR_ON_OFS, {20'h0_0000, `RLY_DLY_MAX_S});
        $display("test delays done");
        give_verdict();
    end
endmodule
